// file: verilog/hwl_pkg.sv
/*
 * constants for the halfword and linked word load unit: instruction
 * encodings, field positions, exception codes, control and status layout.
 * assumes a 64-bit datapath and a 40-bit physical address.
 */
package hwl_pkg;

    // ========================================================
    // widths
    localparam int unsigned HWL_XLEN = 64;
    localparam int unsigned HWL_PSIZE = 40;

    // ========================================================
    // instruction fields
    localparam int unsigned HWL_MAJ_HI = 31;
    localparam int unsigned HWL_MAJ_LO = 26;
    localparam int unsigned HWL_RT_HI = 25;
    localparam int unsigned HWL_RT_LO = 21;
    localparam int unsigned HWL_BASE_HI = 20;
    localparam int unsigned HWL_BASE_LO = 16;
    localparam int unsigned HWL_SUB_HI = 15;
    localparam int unsigned HWL_SUB_LO = 12;
    localparam int unsigned HWL_FN_HI = 11;
    localparam int unsigned HWL_FN_LO = 9;
    localparam int unsigned HWL_D16_W = 16;
    localparam int unsigned HWL_D9_W = 9;

    // encodings
    localparam logic [5:0] HALF_SIGNED_MAJOR_OP = 6'h0f;
    localparam logic [5:0] HALF_UNSIGNED_MAJOR_OP = 6'h0d;
    localparam logic [5:0] POOL_C_MAJOR_OP = 6'h18;
    localparam logic [3:0] USER_MAP_LOAD_SUBOP = 4'h6;
    localparam logic [3:0] LINKED_WORD_SUBOP = 4'h3;
    localparam logic [2:0] FN_HALF_SIGNED_UM = 3'h5;
    localparam logic [2:0] FN_HALF_UNSIGNED_UM = 3'h1;
    localparam logic [2:0] FN_LINKED_ZERO = 3'h0;

    // ========================================================
    // exception codes on o_exc_code
    localparam logic [3:0] EXC_ADDR_ERR = 4'h1;
    localparam logic [3:0] EXC_BUS_ERR = 4'h2;
    localparam logic [3:0] EXC_RESERVED = 4'h3;
    localparam logic [3:0] EXC_COP_UNUSABLE = 4'h4;

    // segment access modes reported by translation
    localparam logic [2:0] SEG_UNMAPPED_USER_KERNEL = 3'h1;
    localparam logic [2:0] SEG_MAPPED_USER_KERNEL = 3'h2;
    localparam logic [2:0] SEG_FULLY_MAPPED_USER_KERNEL = 3'h3;

    // memory access sizes
    localparam logic [1:0] MSZ_HALF = 2'h1;
    localparam logic [1:0] MSZ_WORD = 2'h2;

    // ========================================================
    // register map, byte addresses
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_LOAD_COUNT = 4'h8;

    // control bits
    localparam int unsigned CTRL_EVA = 0;
    localparam int unsigned CTRL_COP0_EN = 1;
    localparam int unsigned CTRL_REL6 = 2;
    localparam int unsigned CTRL_MISALIGN = 3;
    localparam int unsigned CTRL_REV_END = 4;
    localparam int unsigned CTRL_BIG_END = 5;
    localparam int unsigned CTRL_W = 6;
    localparam logic [5:0] CTRL_RESET = 6'h00;

    // status fields
    localparam int unsigned STAT_LINK = 0;
    localparam int unsigned STAT_BUSY = 1;
    localparam int unsigned STAT_EXC_LO = 4;

    // operation kinds
    typedef enum logic [2:0] {
        OPK_NONE,
        OPK_HALF_S,
        OPK_HALF_U,
        OPK_HALF_S_UM,
        OPK_HALF_U_UM,
        OPK_LINKED
    } hwl_op_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_XLAT,
        ST_MEM
    } hwl_state_t;

endpackage : hwl_pkg

// file: verilog/hwl_load_unit.sv
/*
 * halfword loads (signed, unsigned, and user-mapped variants) and the
 * linked word load: decode, address, alignment, lane pick, extension,
 * exceptions and the link flag, with an avalon-mm control slave.
 * assumes the base register value arrives with the instruction, and
 * that translation and memory answer with single-cycle acks.
 */
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
// How it works
// - decode major op 001111 signed half
// - address is sign-extended displacement plus base
// - pre release six: odd halfword address faults
// - release six may allow misaligned halfwords
// - halfword read, endian xor, lane pick
// - signed halfwords sign-extend to 64 bits
// - unsigned halfwords zero-extend to 64 bits
// - decode major op 001101 unsigned half
// - decode pool 011000/0110/101 user-map signed
// - decode pool 011000/0110/001 user-map unsigned
// - user-map signed translates through user mapping
// - user-map unsigned translates through user mapping
// - user-map loads need enhanced addressing bit
// - user-map loads need cop0 and proper segment
// - tlb, bus, address, watch, ri, cu exceptions
// - decode pool 011000/0011/000 linked word
// - linked word sign-extends aligned word lane
// - linked word sets link flag, replaces sequence
// - conditional store ends sequence; abandoning allowed
// - linked load never disturbs other processors
// - linked word faults on low two bits
module hwl_load_unit
    import hwl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    // instruction issue
    input wire logic i_issue_valid,
    input wire logic [31:0] i_instr,
    input wire logic [HWL_XLEN-1:0] i_base_value,
    output logic o_issue_ready,
    // address translation
    output logic o_xlat_req,
    output logic [HWL_XLEN-1:0] o_xlat_vaddr,
    output logic o_xlat_user_map,
    input wire logic i_xlat_ack,
    input wire logic [HWL_PSIZE-1:0] i_xlat_paddr,
    input wire logic [2:0] i_xlat_cache_coherency_attr,
    input wire logic [2:0] i_xlat_seg_mode,
    input wire logic i_xlat_exc,
    input wire logic [3:0] i_xlat_exc_code,
    // memory load path
    output logic o_mem_req,
    output logic [HWL_PSIZE-1:0] o_mem_paddr,
    output logic [1:0] o_mem_size,
    output logic [2:0] o_mem_cache_coherency_attr,
    input wire logic i_mem_ack,
    input wire logic [HWL_XLEN-1:0] i_mem_rdata,
    input wire logic i_mem_bus_err,
    // writeback and exceptions
    output logic o_wb_valid,
    output logic [4:0] o_wb_reg,
    output logic [HWL_XLEN-1:0] o_wb_data,
    output logic o_exc_valid,
    output logic [3:0] o_exc_code,
    // atomic update sequence
    input wire logic i_store_conditional_word_done,
    output logic o_link_flag,
    // avalon-mm slave
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest
);

    // ========================================================
    // functions

    // lane select with sign or zero extension
    function automatic logic [HWL_XLEN-1:0] hwl_pick(
        input logic [HWL_XLEN-1:0] dw,
        input logic [2:0] lane,
        input logic word,
        input logic sgn
    );
        logic [HWL_XLEN-1:0] sh;
        sh = dw >> {lane, 3'h0};
        if (word) begin
            hwl_pick = {{32{sgn & sh[31]}}, sh[31:0]};
        end else begin
            hwl_pick = {{48{sgn & sh[15]}}, sh[15:0]};
        end
    endfunction : hwl_pick

    // ========================================================
    // control registers
    logic [CTRL_W-1:0] ctrl_ff; // software control bits
    logic [31:0] load_count_ff; // completed loads
    logic avs_ack_ff; // one-cycle bus answer
    logic [31:0] avs_rdata_ff; // registered read data
    logic [3:0] last_exc_ff; // last raised exception
    hwl_state_t state_ff; // sequencing state

    logic eva_en;
    logic cop0_en;
    logic rel6;
    logic misalign_en;
    logic rev_end;
    logic big_end;

    assign eva_en = ctrl_ff[CTRL_EVA];
    assign cop0_en = ctrl_ff[CTRL_COP0_EN];
    assign rel6 = ctrl_ff[CTRL_REL6];
    assign misalign_en = ctrl_ff[CTRL_MISALIGN];
    assign rev_end = ctrl_ff[CTRL_REV_END];
    assign big_end = ctrl_ff[CTRL_BIG_END];

    // ========================================================
    // avalon slave: answers every access one cycle after it starts
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~avs_ack_ff;
    assign o_avs_readdata = avs_rdata_ff;

    // answer pulse
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            avs_ack_ff <= 1'b0;
        end else begin
            avs_ack_ff <= (i_avs_read | i_avs_write) & ~avs_ack_ff;
        end
    end

    // read data mux, unmapped reads as zero
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            avs_rdata_ff <= 32'h0;
        end else if (i_avs_read && !avs_ack_ff) begin
            if (i_avs_address == REG_CTRL) begin
                avs_rdata_ff <= {26'h0, ctrl_ff};
            end else if (i_avs_address == REG_STATUS) begin
                avs_rdata_ff <= {24'h0, last_exc_ff, 2'h0,
                                 state_ff != ST_IDLE, o_link_flag};
            end else if (i_avs_address == REG_LOAD_COUNT) begin
                avs_rdata_ff <= load_count_ff;
            end else begin
                avs_rdata_ff <= 32'h0;
            end
        end
    end

    // control write, low byte lane only
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_ff <= CTRL_RESET;
        end else if (i_avs_write && avs_ack_ff &&
                     i_avs_address == REG_CTRL && i_avs_byteenable[0]) begin
            ctrl_ff <= i_avs_writedata[CTRL_W-1:0];
        end
    end

    // ========================================================
    // decode of the issued instruction
    logic [5:0] maj;
    logic [3:0] sub;
    logic [2:0] fn;
    hwl_op_t dec_op;
    logic [HWL_XLEN-1:0] disp;

    assign maj = i_instr[HWL_MAJ_HI:HWL_MAJ_LO];
    assign sub = i_instr[HWL_SUB_HI:HWL_SUB_LO];
    assign fn = i_instr[HWL_FN_HI:HWL_FN_LO];

    // opcode classification
    always_comb begin
        dec_op = OPK_NONE;
        disp = {{(HWL_XLEN-HWL_D9_W){i_instr[HWL_D9_W-1]}},
                i_instr[HWL_D9_W-1:0]};
        if (maj == HALF_SIGNED_MAJOR_OP) begin
            dec_op = OPK_HALF_S;
        end else if (maj == HALF_UNSIGNED_MAJOR_OP) begin
            dec_op = OPK_HALF_U;
        end else if (maj == POOL_C_MAJOR_OP) begin
            if (sub == USER_MAP_LOAD_SUBOP && fn == FN_HALF_SIGNED_UM) begin
                dec_op = OPK_HALF_S_UM;
            end else if (sub == USER_MAP_LOAD_SUBOP &&
                         fn == FN_HALF_UNSIGNED_UM) begin
                dec_op = OPK_HALF_U_UM;
            end else if (sub == LINKED_WORD_SUBOP &&
                         fn == FN_LINKED_ZERO) begin
                dec_op = OPK_LINKED;
            end
        end
        if (dec_op == OPK_HALF_S || dec_op == OPK_HALF_U) begin
            disp = {{(HWL_XLEN-HWL_D16_W){i_instr[HWL_D16_W-1]}},
                    i_instr[HWL_D16_W-1:0]};
        end
    end

    logic [HWL_XLEN-1:0] dec_vaddr;
    logic dec_um;
    logic dec_half;
    logic [2:0] dec_lane;
    logic dec_exc;
    logic [3:0] dec_exc_code;

    assign dec_vaddr = i_base_value + disp;
    assign dec_um = dec_op == OPK_HALF_S_UM || dec_op == OPK_HALF_U_UM;
    assign dec_half = dec_op != OPK_LINKED && dec_op != OPK_NONE;
    assign dec_lane = dec_half ? dec_vaddr[2:0] ^ {big_end, big_end, 1'b0}
                               : dec_vaddr[2:0] ^ {big_end, 2'b00};

    // early faults, all before any translation request
    always_comb begin
        dec_exc = 1'b1;
        dec_exc_code = EXC_RESERVED;
        if (dec_op == OPK_NONE) begin
            dec_exc_code = EXC_RESERVED;
        end else if (dec_um && !eva_en) begin
            dec_exc_code = EXC_RESERVED;
        end else if (dec_um && !cop0_en) begin
            dec_exc_code = EXC_COP_UNUSABLE;
        end else if (!dec_half && dec_vaddr[1:0] != 2'b00) begin
            dec_exc_code = EXC_ADDR_ERR;
        end else if (dec_half && dec_vaddr[0] &&
                     !(rel6 && misalign_en && dec_lane != 3'h7)) begin
            dec_exc_code = EXC_ADDR_ERR;
        end else begin
            dec_exc = 1'b0;
        end
    end

    // ========================================================
    // held operation
    hwl_op_t op_ff;
    logic [HWL_XLEN-1:0] vaddr_ff;
    logic [4:0] rt_ff;
    logic [2:0] lane_ff;
    logic [HWL_PSIZE-1:0] paddr_ff;
    logic [2:0] cca_ff;
    logic take;
    logic op_um;
    logic op_half;

    assign o_issue_ready = state_ff == ST_IDLE;
    assign take = i_issue_valid && o_issue_ready;
    assign op_um = op_ff == OPK_HALF_S_UM || op_ff == OPK_HALF_U_UM;
    assign op_half = op_ff != OPK_LINKED;

    // capture of an accepted load
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            op_ff <= OPK_NONE;
            vaddr_ff <= '0;
            rt_ff <= 5'h0;
            lane_ff <= 3'h0;
        end else if (take) begin
            op_ff <= dec_op;
            vaddr_ff <= dec_vaddr;
            rt_ff <= i_instr[HWL_RT_HI:HWL_RT_LO];
            lane_ff <= dec_lane;
        end
    end

    // segment mode check for user-map variants
    logic seg_ok;
    assign seg_ok = i_xlat_seg_mode == SEG_UNMAPPED_USER_KERNEL ||
                    i_xlat_seg_mode == SEG_MAPPED_USER_KERNEL ||
                    i_xlat_seg_mode == SEG_FULLY_MAPPED_USER_KERNEL;

    // ========================================================
    // sequencing: idle, translate, memory read
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_ff <= ST_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (take && !dec_exc) begin
                        state_ff <= ST_XLAT;
                    end
                end
                ST_XLAT: begin
                    if (i_xlat_ack) begin
                        if (i_xlat_exc || (op_um && !seg_ok)) begin
                            state_ff <= ST_IDLE;
                        end else begin
                            state_ff <= ST_MEM;
                        end
                    end
                end
                ST_MEM: begin
                    if (i_mem_ack) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    assign o_xlat_req = state_ff == ST_XLAT;
    assign o_xlat_vaddr = vaddr_ff;
    assign o_xlat_user_map = op_um;
    assign o_mem_req = state_ff == ST_MEM;
    assign o_mem_paddr = paddr_ff;
    assign o_mem_cache_coherency_attr = cca_ff;
    assign o_mem_size = op_half ? MSZ_HALF : MSZ_WORD;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            paddr_ff <= '0;
            cca_ff <= 3'h0;
        end else if (o_xlat_req && i_xlat_ack) begin
            cca_ff <= i_xlat_cache_coherency_attr;
            paddr_ff <= {i_xlat_paddr[HWL_PSIZE-1:3],
                         i_xlat_paddr[2:0] ^ (op_half
                             ? {rev_end, rev_end, 1'b0}
                             : {rev_end, 2'b00})};
        end
    end

    // ========================================================
    // results and exceptions, one-cycle pulses
    logic nxt_wb;
    assign nxt_wb = o_mem_req && i_mem_ack && !i_mem_bus_err;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_wb_valid <= 1'b0;
            o_wb_reg <= 5'h0;
            o_wb_data <= '0;
        end else begin
            o_wb_valid <= nxt_wb;
            if (nxt_wb) begin
                o_wb_reg <= rt_ff;
                o_wb_data <= hwl_pick(i_mem_rdata, lane_ff, !op_half,
                                      op_ff != OPK_HALF_U &&
                                      op_ff != OPK_HALF_U_UM);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_exc_valid <= 1'b0;
            o_exc_code <= 4'h0;
        end else if (take && dec_exc) begin
            o_exc_valid <= 1'b1;
            o_exc_code <= dec_exc_code;
        end else if (o_xlat_req && i_xlat_ack && i_xlat_exc) begin
            o_exc_valid <= 1'b1;
            o_exc_code <= i_xlat_exc_code;
        end else if (o_xlat_req && i_xlat_ack && op_um && !seg_ok) begin
            o_exc_valid <= 1'b1;
            o_exc_code <= EXC_RESERVED;
        end else if (o_mem_req && i_mem_ack && i_mem_bus_err) begin
            o_exc_valid <= 1'b1;
            o_exc_code <= EXC_BUS_ERR;
        end else begin
            o_exc_valid <= 1'b0;
        end
    end

    // last exception and completed-load count for status
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            last_exc_ff <= 4'h0;
            load_count_ff <= 32'h0;
        end else begin
            if (o_exc_valid) begin
                last_exc_ff <= o_exc_code;
            end
            if (o_wb_valid) begin
                load_count_ff <= load_count_ff + 32'h1;
            end
        end
    end

    // link flag: a linked load sets, conditional store
    // clears; the set wins; the flag is purely local
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_link_flag <= 1'b0;
        end else if (nxt_wb && op_ff == OPK_LINKED) begin
            o_link_flag <= 1'b1;
        end else if (i_store_conditional_word_done) begin
            o_link_flag <= 1'b0;
        end
    end

    // ========================================================
    // assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    half_align_a: assert property (
        take && dec_half && !rel6 && dec_vaddr[0] &&
            (!dec_um || (eva_en && cop0_en)) |=>
            o_exc_valid && o_exc_code == EXC_ADDR_ERR && !o_xlat_req)
        else $error("odd halfword address not faulted");
    linked_align_a: assert property (
        take && dec_op == OPK_LINKED && dec_vaddr[1:0] != 2'b00 |=>
            o_exc_valid && o_exc_code == EXC_ADDR_ERR && o_issue_ready)
        else $error("misaligned linked word not faulted");
    no_wb_fault_a: assert property (
        !(o_wb_valid && o_exc_valid))
        else $error("writeback together with fault");
    eva_gate_a: assert property (
        take && dec_um && !eva_en |=> o_exc_valid &&
            o_exc_code == EXC_RESERVED && !o_xlat_req)
        else $error("user-map load ran without enhanced addressing");
    cop_gate_a: assert property (
        take && dec_um && eva_en && !cop0_en |=>
            o_exc_valid && o_exc_code == EXC_COP_UNUSABLE)
        else $error("user-map load ran without cop0 access");
    sign_half_a: assert property (
        o_wb_valid && $past(op_ff == OPK_HALF_S ||
            op_ff == OPK_HALF_S_UM) |->
            o_wb_data[63:16] == {48{o_wb_data[15]}})
        else $error("signed halfword not sign-extended");
    zero_half_a: assert property (
        o_wb_valid && $past(op_ff == OPK_HALF_U ||
            op_ff == OPK_HALF_U_UM) |->
            o_wb_data[63:16] == 48'h0)
        else $error("unsigned halfword not zero-extended");
    word_ext_a: assert property (
        o_wb_valid && $past(op_ff == OPK_LINKED) |->
            o_wb_data[63:32] == {32{o_wb_data[31]}})
        else $error("linked word not sign-extended");
    link_set_a: assert property (
        nxt_wb && op_ff == OPK_LINKED |=> o_link_flag && o_wb_valid)
        else $error("link flag not set by linked load");
    user_map_a: assert property (
        take && !dec_exc |=> o_xlat_req && o_xlat_user_map ==
            $past(maj == POOL_C_MAJOR_OP && sub == USER_MAP_LOAD_SUBOP))
        else $error("wrong mapping requested");
    mem_size_a: assert property (
        o_mem_req |-> o_mem_size == (op_ff == OPK_LINKED ? MSZ_WORD
                                                          : MSZ_HALF))
        else $error("halfword load used wrong size");

    linked_done_c: cover property (nxt_wb && op_ff == OPK_LINKED);
    um_half_c: cover property (nxt_wb && op_ff == OPK_HALF_S_UM);
    bus_err_c: cover property (o_mem_req && i_mem_ack && i_mem_bus_err);
    sc_clear_c: cover property (o_link_flag ##1 !o_link_flag);

endmodule : hwl_load_unit

// file: tb/hwl_far_model.sv
/* far side: translation with an identity map, and memory reads.
   assumes one request at a time from the load unit. */
module hwl_far_model
    import hwl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_xreq,
    input wire logic [HWL_XLEN-1:0] i_vaddr,
    input wire logic i_mreq,
    input wire logic [1:0] i_dly,
    input wire logic [HWL_XLEN-1:0] i_data,
    input wire logic i_berr,
    output logic o_xack,
    output logic [HWL_PSIZE-1:0] o_paddr,
    output logic o_mack,
    output logic [HWL_XLEN-1:0] o_rdata,
    output logic o_berr
);
    timeunit 1ns;
    timeprecision 100ps;
    // ====================
    logic [1:0] wait_ff; // cycles spent on the pending request
    logic busy;
    logic go;
    assign busy = (i_xreq | i_mreq) & ~o_xack & ~o_mack;
    assign go = busy & (wait_ff == i_dly);
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wait_ff <= 2'h0;
            o_xack <= 1'b0;
            o_mack <= 1'b0;
            o_paddr <= '0;
            o_rdata <= '0;
            o_berr <= 1'b0;
        end else begin
            wait_ff <= (busy & ~go) ? wait_ff + 2'h1 : 2'h0;
            o_xack <= go & i_xreq;
            o_mack <= go & i_mreq;
            o_berr <= go & i_mreq & i_berr;
            // released lines invert so stale values never match
            o_paddr <= go ? i_vaddr[HWL_PSIZE-1:0] : ~o_paddr;
            o_rdata <= (go & i_mreq) ? i_data : ~o_rdata;
        end
    end
endmodule : hwl_far_model

// file: tb/hwl_load_unit_tb.sv
/* bench: random loads against a reference model of the load unit.
   assumes the far-side model answers translation and memory. */
module hwl_load_unit_tb;
    import hwl_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_n, iv, rdy, xr, um, xa, mr, ma, be, wb, ex, sc, lk;
    logic rd, wr, wq, eb, lkx, xe;
    logic [31:0] ins, wd, q, rq;
    logic [63:0] bs, va, md, rdat, wdat;
    logic [39:0] pa, mpa;
    logic [1:0] msz, dl;
    logic [4:0] wreg;
    logic [3:0] ec, aa;
    logic [2:0] seg, cca;
    logic [5:0] c;
    int fail_count = 0;
    int total_checks = 0;
    int nwb = 0;
    hwl_load_unit dut_u (.i_clk(clk), .i_arst_n(rst_n), .i_issue_valid(iv),
        .i_instr(ins), .i_base_value(bs), .o_issue_ready(rdy),
        .o_xlat_req(xr), .o_xlat_vaddr(va), .o_xlat_user_map(um),
        .i_xlat_ack(xa), .i_xlat_paddr(pa), .i_xlat_seg_mode(seg),
        .i_xlat_cache_coherency_attr(seg), .i_xlat_exc(xe),
        .i_xlat_exc_code(4'h5), .o_mem_req(mr), .o_mem_paddr(mpa),
        .o_mem_size(msz), .o_mem_cache_coherency_attr(cca), .i_mem_ack(ma),
        .i_mem_rdata(rdat), .i_mem_bus_err(be), .o_wb_valid(wb),
        .o_wb_reg(wreg), .o_wb_data(wdat), .o_exc_valid(ex), .o_exc_code(ec),
        .i_store_conditional_word_done(sc), .o_link_flag(lk),
        .i_avs_address(aa), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(q),
        .o_avs_waitrequest(wq));
    hwl_far_model far_u (.i_clk(clk), .i_arst_n(rst_n), .i_xreq(xr),
        .i_vaddr(va), .i_mreq(mr), .i_dly(dl), .i_data(md), .i_berr(eb),
        .o_xack(xa), .o_paddr(pa), .o_mack(ma), .o_rdata(rdat), .o_berr(be));
    // ====================
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // bus cycle: hold until waitrequest low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        aa <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do begin @(posedge clk); n++; end while (wq !== 1'b0 && n < 40);
        if (wq !== 1'b0) fail_count++;
        rq = q;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic load(input int k);
        logic [31:0] r;
        logic [63:0] b, ea, sh, m;
        logic [3:0] xc;
        logic [2:0] ln, sg;
        logic hw, u, ef, xs, e, x;
        int n;
        r = $urandom;
        b = {$urandom, $urandom};
        m = {$urandom, $urandom};
        sg = 3'($urandom);
        e = ($urandom % 8) == 0;
        x = ($urandom % 8) == 0;
        hw = k < 4;
        u = k == 2 || k == 3;
        if (k == 4) r[15:12] = LINKED_WORD_SUBOP;
        if (u) r[15:12] = USER_MAP_LOAD_SUBOP;
        case (k)
            0: ins <= {HALF_SIGNED_MAJOR_OP, r[25:0]};
            1: ins <= {HALF_UNSIGNED_MAJOR_OP, r[25:0]};
            2: ins <= {POOL_C_MAJOR_OP, r[25:12], FN_HALF_SIGNED_UM, r[8:0]};
            3: ins <= {POOL_C_MAJOR_OP, r[25:12], FN_HALF_UNSIGNED_UM, r[8:0]};
            4: ins <= {POOL_C_MAJOR_OP, r[25:12], FN_LINKED_ZERO, r[8:0]};
            default: ins <= {6'h3f, r[25:0]};
        endcase
        ea = b + (k < 2 ? {{48{r[15]}}, r[15:0]} : {{55{r[8]}}, r[8:0]});
        ln = ea[2:0] ^ {c[5], c[5] & hw, 1'b0};
        ef = 1'b1;
        if (k == 5 || (u && !c[0])) xc = EXC_RESERVED;
        else if (u && !c[1]) xc = EXC_COP_UNUSABLE;
        else if (hw ? ea[0] && !(c[2] && c[3] && ln != 3'h7) : ea[1:0] != 2'h0)
            xc = EXC_ADDR_ERR;
        else begin
            ef = 1'b0;
            xc = x ? 4'h5 : (u && (sg == 3'h0 || sg > 3'h3)) ? EXC_RESERVED
                : e ? EXC_BUS_ERR : 4'h0;
        end
        sh = m >> (8 * ln);
        sh = k == 4 ? {{32{sh[31]}}, sh[31:0]} : (k == 1 || k == 3)
            ? {48'h0, sh[15:0]} : {{48{sh[15]}}, sh[15:0]};
        bs <= b;
        md <= m;
        seg <= sg;
        eb <= e;
        xe <= x;
        dl <= 2'($urandom);
        iv <= 1'b1;
        sc <= r[31] & r[30];
        @(posedge clk);
        iv <= 1'b0;
        sc <= 1'b0;
        if (r[31] & r[30]) lkx = 1'b0;
        if (k == 4 && xc == 4'h0) lkx = 1'b1;
        n = 0;
        xs = 1'b0;
        do begin
            @(negedge clk);
            n++;
            xs |= xr & !rdy;
            if (xa === 1'b1) chk(va, ea);
            if (ma === 1'b1) begin
                chk(mpa, {ea[39:3], ea[2:0] ^ {c[4], c[4] & hw, 1'b0}});
                chk(msz, hw ? MSZ_HALF : MSZ_WORD);
                chk(um, u);
                chk(cca, sg);
            end
        end while (wb !== 1'b1 && ex !== 1'b1 && n < 60);
        chk(xs, !ef);
        chk(wb, xc == 4'h0);
        chk(ex, xc != 4'h0);
        if (xc != 4'h0) chk(ec, xc);
        else begin
            chk(wdat, sh);
            chk(wreg, r[25:21]);
            nwb++;
        end
        chk(lk, lkx);
        @(posedge clk);
    endtask : load
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        end_of_test;
    end
    initial begin
        {rst_n, iv, sc, rd, wr, eb, lkx, ins, wd, bs, md, dl, aa, seg, c} = '0;
        xe = 1'b0;
        void'($urandom(90062));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 90; i++) begin
            c = 6'($urandom);
            bus(1'b1, REG_CTRL, {26'h0, c});
            load($urandom % 6);
        end
        $display("test random loads done");
        bus(1'b0, REG_STATUS, 32'h0);
        chk(rq[STAT_LINK], lkx);
        bus(1'b0, REG_LOAD_COUNT, 32'h0);
        chk(rq, nwb);
        bus(1'b0, 4'hc, 32'h0);
        chk(rq, 64'h0);
        $display("test register reads done");
        end_of_test;
    end
endmodule : hwl_load_unit_tb
